//--- core/fat_pkg.sv
// constants, register map and state types for the frame acquisition trigger control
package fat_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int EXP_W  = 24;
    localparam int CNT_W  = 16;
    localparam int BST_W  = 8;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_CMD      = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE     = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_SEL      = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_TRIG     = 6'h0c;
    localparam logic [ADDR_W-1:0] OFF_EXP_MODE = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_EXP_TIME = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_PERIOD   = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_BURST    = 6'h1c;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 6'h20;

    // field positions
    localparam int CMD_START_BIT  = 0;
    localparam int CMD_STOP_BIT   = 1;
    localparam int CMD_SWTRIG_BIT = 2;
    localparam int TRIG_MODE_BIT  = 0;
    localparam int TRIG_SRC_BIT   = 1;
    localparam int TRIG_ACT_BIT   = 2;
    localparam int STAT_PEND_BIT  = 2;
    localparam int STAT_SEEN_LSB  = 8;

    // trigger selector indices and source encoding
    localparam int   TRIG_IMAGE = 0;
    localparam int   TRIG_GROUP = 1;
    localparam logic SRC_SW     = 1'b0;
    localparam logic SRC_LINE1  = 1'b1;

    // reset values and timing counts, in clock cycles
    localparam logic [EXP_W-1:0] RST_EXP_TIME   = 24'h0003e8;
    localparam logic [EXP_W-1:0] RST_PERIOD     = 24'h002710;
    localparam logic [BST_W-1:0] RST_BURST      = 8'h01;
    localparam logic [CNT_W-1:0] SETUP_CYCLES   = 16'h0010;
    localparam logic [CNT_W-1:0] READOUT_CYCLES = 16'h0040;

    typedef enum logic [2:0] {
        ST_STOPPED    = 3'b000,
        ST_WAIT_GROUP = 3'b001,
        ST_WAIT_IMAGE = 3'b010,
        ST_FRAME      = 3'b011
    } fat_state_t;

    typedef enum logic [1:0] {
        PH_IDLE    = 2'b00,
        PH_SETUP   = 2'b01,
        PH_EXPOSE  = 2'b10,
        PH_READOUT = 2'b11
    } fat_phase_t;

endpackage : fat_pkg

//--- core/fat_frame_if.sv
// control/status bundle between the acquisition controller and the frame engine
`timescale 1ns/100ps
interface fat_frame_if;
    logic                      start;
    logic                      setup_req;
    logic                      width_mode;
    logic                      line_active;
    logic [fat_pkg::EXP_W-1:0] exp_cycles;
    logic [fat_pkg::CNT_W-1:0] setup_cycles;
    logic [fat_pkg::CNT_W-1:0] ro_cycles;
    logic                      exposing;
    logic                      reading;
    logic                      done;

    modport ctl (
        output start, setup_req, width_mode, line_active, exp_cycles, setup_cycles, ro_cycles,
        input  exposing, reading, done
    );
    modport eng (
        input  start, setup_req, width_mode, line_active, exp_cycles, setup_cycles, ro_cycles,
        output exposing, reading, done
    );
endinterface : fat_frame_if

//--- core/fat_trig_edge.sv
// synchroniser and edge detector for one hardware trigger
`timescale 1ns/100ps
module fat_trig_edge (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic line_in,
    input  wire logic falling,
    output logic      event_pulse,
    output logic      active
);
    import fat_pkg::*;

    logic sync0;
    logic sync1;
    logic prev;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync0       <= 1'b0;
            sync1       <= 1'b0;
            prev        <= 1'b0;
            event_pulse <= 1'b0;
            active      <= 1'b0;
        end
        else if (ce)
        begin
            sync0       <= line_in;
            sync1       <= sync0;
            prev        <= sync1;
            event_pulse <= falling ? (prev & ~sync1) : (~prev & sync1);
            active      <= sync1 ^ falling;
        end
    end

    edge_single_a: assert property (@(posedge clock) disable iff (sys_rst)
        (event_pulse && ce) |=> !event_pulse)
        else $error("trigger event lasted more than one cycle");

endmodule : fat_trig_edge

//--- core/fat_frame_engine.sv
// setup, exposure and readout sequencer for one frame
`timescale 1ns/100ps
module fat_frame_engine (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic ce,
    fat_frame_if.eng  frm
);
    import fat_pkg::*;

    fat_phase_t             phase;
    logic [EXP_W-1:0]       cnt;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            phase        <= PH_IDLE;
            cnt          <= '0;
            frm.exposing <= 1'b0;
            frm.reading  <= 1'b0;
            frm.done     <= 1'b0;
        end
        else if (ce)
        begin
            frm.done <= 1'b0;
            case (phase)
                PH_IDLE:
                begin
                    if (frm.start && frm.setup_req)
                    begin
                        phase <= PH_SETUP;
                        cnt   <= EXP_W'(frm.setup_cycles);
                    end
                    else if (frm.start)
                    begin
                        phase        <= PH_EXPOSE;
                        frm.exposing <= 1'b1;
                        cnt          <= frm.exp_cycles;
                    end
                end
                PH_SETUP:
                begin
                    if (cnt <= 1)
                    begin
                        phase        <= PH_EXPOSE;
                        frm.exposing <= 1'b1;
                        cnt          <= frm.exp_cycles;
                    end
                    else
                        cnt <= cnt - 1'b1;
                end
                PH_EXPOSE:
                begin
                    // width mode ends on the trailing edge, timed mode on the count
                    if (frm.width_mode ? !frm.line_active : (cnt <= 1))
                    begin
                        phase        <= PH_READOUT;
                        frm.exposing <= 1'b0;
                        frm.reading  <= 1'b1;
                        cnt          <= EXP_W'(frm.ro_cycles);
                    end
                    else
                        cnt <= cnt - 1'b1;
                end
                PH_READOUT:
                begin
                    if (cnt <= 1)
                    begin
                        phase       <= PH_IDLE;
                        frm.reading <= 1'b0;
                        frm.done    <= 1'b1;
                    end
                    else
                        cnt <= cnt - 1'b1;
                end
                default:
                    phase <= PH_IDLE;
            endcase
        end
    end

    setup_first_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase == PH_IDLE && frm.start && frm.setup_req && ce) |=> phase == PH_SETUP && !frm.exposing)
        else $error("single-frame start skipped setup");
    width_end_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase == PH_EXPOSE && frm.width_mode && !frm.line_active && ce) |=> !frm.exposing)
        else $error("width exposure outlived the trigger pulse");
    timed_end_a: assert property (@(posedge clock) disable iff (sys_rst)
        (phase == PH_EXPOSE && !frm.width_mode && cnt == 2 && ce) ##1 ce |=> !frm.exposing)
        else $error("timed exposure ran past its count");

endmodule : fat_frame_engine

//--- core/fat_acq_ctrl.sv
// frame acquisition trigger control: start/stop, burst and frame triggers, register port
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module fat_acq_ctrl #(
    parameter logic [fat_pkg::CNT_W-1:0] SETUP_LEN   = fat_pkg::SETUP_CYCLES,
    parameter logic [fat_pkg::CNT_W-1:0] READOUT_LEN = fat_pkg::READOUT_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    input  wire logic                        ce,
    input  wire logic [fat_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [fat_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [fat_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        trig_line1,
    output logic      [1:0]                  acq_state,
    output logic                             exposing,
    output logic                             reading,
    output logic                             frame_done
);
    import fat_pkg::*;

    // configuration
    logic                   acq_continuous;
    logic                   trig_sel;
    logic [1:0]             trig_mode;
    logic [1:0]             trig_src;
    logic [1:0]             trig_act;
    logic                   exp_width_mode;
    logic [EXP_W-1:0]       exp_time;
    logic [EXP_W-1:0]       frame_period;
    logic [BST_W-1:0]       burst_count;

    // control state
    fat_state_t             state;
    logic                   stop_pending;
    logic [BST_W-1:0]       burst_seen;
    logic [EXP_W-1:0]       period_cnt;

    // events
    logic                   cmd_wr;
    logic                   cmd_start;
    logic                   cmd_stop;
    logic [1:0]             edge_ev;
    logic [1:0]             line_act;
    logic [1:0]             sw_ev;
    logic [1:0]             ext_ev;
    logic                   int_tick;
    logic                   group_go;
    logic                   image_go;
    logic                   burst_full;

    fat_frame_if frm ();

    function automatic logic [1:0] status_code(input fat_state_t s);
        case (s)
            ST_STOPPED:    status_code = 2'h0;
            ST_WAIT_GROUP: status_code = 2'h1;
            ST_WAIT_IMAGE: status_code = 2'h2;
            default:       status_code = 2'h3;
        endcase
    endfunction : status_code

    assign cmd_wr    = reg_wr && (reg_addr == OFF_CMD);
    assign cmd_start = cmd_wr && reg_wdata[CMD_START_BIT];
    assign cmd_stop  = cmd_wr && reg_wdata[CMD_STOP_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_trig
            fat_trig_edge u_edge (
                .clock       (clock),
                .sys_rst     (sys_rst),
                .ce          (ce),
                .line_in     (trig_line1),
                .falling     (trig_act[gi]),
                .event_pulse (edge_ev[gi]),
                .active      (line_act[gi])
            );
            // software command only reaches the selected trigger
            assign sw_ev[gi]  = cmd_wr && reg_wdata[CMD_SWTRIG_BIT] && (trig_sel == 1'(gi))
                                && (trig_src[gi] == SRC_SW);
            assign ext_ev[gi] = trig_mode[gi] && (sw_ev[gi]
                                || (edge_ev[gi] && trig_src[gi] == SRC_LINE1));
        end
    endgenerate

    assign int_tick   = (period_cnt >= frame_period);
    assign group_go   = trig_mode[TRIG_GROUP] ? ext_ev[TRIG_GROUP] : 1'b1;
    assign image_go   = trig_mode[TRIG_IMAGE] ? ext_ev[TRIG_IMAGE] : int_tick;
    assign burst_full = trig_mode[TRIG_GROUP] && (burst_seen == burst_count);

    // configuration registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            acq_continuous <= 1'b0;
            trig_sel       <= 1'b0;
            trig_mode      <= 2'b00;
            trig_src       <= 2'b00;
            trig_act       <= 2'b00;
            exp_width_mode <= 1'b0;
            exp_time       <= RST_EXP_TIME;
            frame_period   <= RST_PERIOD;
            burst_count    <= RST_BURST;
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                OFF_MODE:     acq_continuous <= reg_wdata[0];
                OFF_SEL:      trig_sel       <= reg_wdata[0];
                OFF_TRIG:
                begin
                    trig_mode[trig_sel] <= reg_wdata[TRIG_MODE_BIT];
                    trig_src[trig_sel]  <= reg_wdata[TRIG_SRC_BIT];
                    trig_act[trig_sel]  <= reg_wdata[TRIG_ACT_BIT];
                end
                OFF_EXP_MODE: exp_width_mode <= reg_wdata[0];
                OFF_EXP_TIME: exp_time       <= reg_wdata[EXP_W-1:0];
                OFF_PERIOD:   frame_period   <= reg_wdata[EXP_W-1:0];
                OFF_BURST:    burst_count    <= reg_wdata[BST_W-1:0];
                default:      ;
            endcase
        end
    end

    // acquisition state machine
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state        <= ST_STOPPED;
            stop_pending <= 1'b0;
            burst_seen   <= '0;
            frm.start    <= 1'b0;
        end
        else if (ce)
        begin
            frm.start <= 1'b0;
            case (state)
                ST_STOPPED:
                begin
                    if (cmd_start)
                    begin
                        state        <= ST_WAIT_GROUP;
                        stop_pending <= 1'b0;
                    end
                end
                ST_WAIT_GROUP:
                begin
                    // image triggers are not looked at here
                    if (cmd_stop)
                        state <= ST_STOPPED;
                    else if (group_go)
                    begin
                        state      <= ST_WAIT_IMAGE;
                        burst_seen <= '0;
                    end
                end
                ST_WAIT_IMAGE:
                begin
                    if (cmd_stop)
                        state <= ST_STOPPED;
                    else if (image_go)
                    begin
                        state      <= ST_FRAME;
                        frm.start  <= 1'b1;
                        burst_seen <= burst_seen + 1'b1;
                    end
                end
                ST_FRAME:
                begin
                    if (frm.done)
                    begin
                        if (stop_pending || cmd_stop || !acq_continuous)
                            state <= ST_STOPPED;
                        else if (burst_full)
                            state <= ST_WAIT_GROUP;
                        else
                            state <= ST_WAIT_IMAGE;
                    end
                    else if (cmd_stop)
                        stop_pending <= 1'b1;
                end
                default:
                    state <= ST_STOPPED;
            endcase
        end
    end

    // internal frame-rate timer, restarted at every frame start
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            period_cnt <= '0;
        else if (ce)
        begin
            if (state == ST_STOPPED || frm.start)
                period_cnt <= '0;
            else if (!int_tick)
                period_cnt <= period_cnt + 1'b1;
        end
    end

    // engine set-up; no overlap, the next start waits for done
    assign frm.setup_req    = !acq_continuous;
    assign frm.width_mode   = exp_width_mode && trig_mode[TRIG_IMAGE]
                              && (trig_src[TRIG_IMAGE] == SRC_LINE1);
    assign frm.line_active  = line_act[TRIG_IMAGE];
    assign frm.exp_cycles   = exp_time;
    assign frm.setup_cycles = SETUP_LEN;
    assign frm.ro_cycles    = READOUT_LEN;

    fat_frame_engine u_engine (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ce      (ce),
        .frm     (frm)
    );

    assign exposing   = frm.exposing;
    assign reading    = frm.reading;
    assign frame_done = frm.done;

    // status output lags the state by one cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            acq_state <= 2'h0;
        else if (ce)
            acq_state <= status_code(state);
    end

    // read port; data valid only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (ce)
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                case (reg_addr)
                    OFF_MODE:     reg_rdata[0] <= acq_continuous;
                    OFF_SEL:      reg_rdata[0] <= trig_sel;
                    OFF_TRIG:
                    begin
                        reg_rdata[TRIG_MODE_BIT] <= trig_mode[trig_sel];
                        reg_rdata[TRIG_SRC_BIT]  <= trig_src[trig_sel];
                        reg_rdata[TRIG_ACT_BIT]  <= trig_act[trig_sel];
                    end
                    OFF_EXP_MODE: reg_rdata[0] <= exp_width_mode;
                    OFF_EXP_TIME: reg_rdata[EXP_W-1:0] <= exp_time;
                    OFF_PERIOD:   reg_rdata[EXP_W-1:0] <= frame_period;
                    OFF_BURST:    reg_rdata[BST_W-1:0] <= burst_count;
                    OFF_STATUS:
                    begin
                        reg_rdata[1:0]                         <= status_code(state);
                        reg_rdata[STAT_PEND_BIT]               <= stop_pending;
                        reg_rdata[STAT_SEEN_LSB+BST_W-1:STAT_SEEN_LSB] <= burst_seen;
                    end
                    default:      ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    group_enter_a: assert property (
        (state == ST_WAIT_GROUP && group_go && !cmd_stop && ce) |=> state == ST_WAIT_IMAGE)
        else $error("group trigger did not open the image wait");
    image_start_a: assert property (
        (state == ST_WAIT_IMAGE && image_go && !cmd_stop && ce)
        |=> state == ST_FRAME && frm.start ##2 (frm.exposing || frm.setup_req))
        else $error("image trigger did not start a frame");
    frame_return_a: assert property (
        (state == ST_FRAME && frm.done && ce && acq_continuous && !stop_pending
         && !cmd_stop && !burst_full) |=> state == ST_WAIT_IMAGE)
        else $error("frame end did not rearm the image wait");
    int_tick_a: assert property (
        (state == ST_WAIT_IMAGE && !trig_mode[TRIG_IMAGE] && int_tick && !cmd_stop && ce)
        |=> state == ST_FRAME)
        else $error("internal frame timer did not start a frame");
    drop_trig_a: assert property (
        (state != ST_WAIT_IMAGE && ce) |=> !frm.start)
        else $error("frame started outside the image wait");
    stop_idle_a: assert property (
        (cmd_stop && ce && (state == ST_WAIT_GROUP || state == ST_WAIT_IMAGE))
        |=> state == ST_STOPPED)
        else $error("stop while idle did not take effect");
    stop_defer_a: assert property (
        (cmd_stop && ce && state == ST_FRAME && !frm.done) |=> state == ST_FRAME && stop_pending)
        else $error("stop during a frame cut the frame short");
    single_stop_a: assert property (
        (state == ST_FRAME && frm.done && ce && !acq_continuous) |=> state == ST_STOPPED)
        else $error("single-frame mode did not stop itself");
    no_start_a: assert property (
        (state == ST_STOPPED && !cmd_start && ce) |=> state == ST_STOPPED && !frm.start)
        else $error("acquisition left stop without a start command");
    burst_end_a: assert property (
        (state == ST_FRAME && frm.done && ce && acq_continuous && !stop_pending && !cmd_stop
         && burst_full) |=> state == ST_WAIT_GROUP)
        else $error("burst count reached but group wait not re-entered");

    burst_done_c:  cover property (state == ST_FRAME && frm.done && burst_full ##1
                                   state == ST_WAIT_GROUP);
    single_done_c: cover property (state == ST_FRAME && frm.done && !acq_continuous);
    width_exp_c:   cover property (frm.exposing && frm.width_mode ##1 frm.reading);
    stop_defer_c:  cover property (stop_pending && frm.done);

endmodule : fat_acq_ctrl

//--- verification/fat_trig_src.sv
// model of the external trigger source that drives line 1
`timescale 1ns/100ps
module fat_trig_src (
    input  wire logic       clock,
    input  wire logic       fire,
    input  wire logic [7:0] width,
    output logic            line
);
    logic [7:0] cnt = 8'h00;
    initial line = 1'b0;
    // one clean pulse per fire, high for width cycles
    always @(posedge clock)
    begin
        cnt <= fire ? width : cnt - 8'(cnt != 8'h00);
        line <= fire || cnt > 8'h01;
    end
endmodule : fat_trig_src

//--- verification/tb_fat_acq_ctrl.sv
// self-checking bench for the acquisition trigger controller
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %0h want %0h", $time, g, e); end end
module tb_fat_acq_ctrl;
    import fat_pkg::*;
    logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fire = 1'b0;
    logic        trig_line1, exposing, reading, frame_done;
    logic [5:0]  reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v, e;
    logic [1:0]  acq_state;
    int          num_errors = 0, tests_run = 0, exp_n = 0, last_exp = 0, frames = 0;
    fat_acq_ctrl #(.SETUP_LEN(16'h0002), .READOUT_LEN(16'h0002)) dut_u (.clock(clock),
        .sys_rst(sys_rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_line1(trig_line1),
        .acq_state(acq_state), .exposing(exposing), .reading(reading), .frame_done(frame_done));
    fat_trig_src src_u (.clock(clock), .fire(fire), .width(8'h03), .line(trig_line1));
    initial forever #50 clock = ~clock;
    always @(posedge clock)
    begin
        exp_n <= frame_done === 1'b1 ? 0 : exp_n + int'(exposing === 1'b1);
        if (frame_done === 1'b1) last_exp <= exp_n;
        frames <= frames + int'(frame_done === 1'b1);
    end
    task automatic conclude;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task automatic strobe(input logic rd, input logic [5:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= rd;
        reg_wr <= !rd;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        #1 rd_v = reg_rdata;
        @(posedge clock);
    endtask : strobe
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic pulse;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
    endtask : pulse
    task automatic wait_done;
        int i;
        for (i = 0; i < 400 && frame_done !== 1'b1; i++) settle(1);
        if (i == 400) begin num_errors++; conclude(); end
        settle(2);
    endtask : wait_done
    initial
    begin
        void'($urandom(32'h68df5292));
        settle(6);
        sys_rst <= 1'b0;
        settle(1);
        strobe(1'b1, OFF_EXP_TIME, 0);
        `CHK(rd_v, {8'h00, RST_EXP_TIME})
        strobe(1'b1, 6'h3c, 0);
        `CHK(rd_v, 32'h0)
        e = 32'($urandom_range(12, 8));
        strobe(1'b0, OFF_EXP_TIME, e);
        strobe(1'b0, OFF_TRIG, 32'h1);
        strobe(1'b0, OFF_CMD, 32'h4);
        settle(3);
        `CHK({acq_state, frames}, {2'h0, 32'd0})
        strobe(1'b0, OFF_CMD, 32'h1);
        strobe(1'b0, OFF_CMD, 32'h4);
        wait_done();
        `CHK({acq_state, last_exp}, {2'h0, e})
        $display("single frame test ended");
        strobe(1'b0, OFF_MODE, 32'h1);
        strobe(1'b0, OFF_TRIG, 32'h3);
        strobe(1'b0, OFF_CMD, 32'h1);
        for (int k = 1; k <= 3; k++)
        begin
            pulse();
            settle(6);
            pulse(); // lands mid-frame, must be ignored
            wait_done();
            settle(12);
            `CHK({acq_state, last_exp, frames}, {2'h2, e, k + 1})
        end
        strobe(1'b0, OFF_CMD, 32'h2);
        settle(1);
        `CHK(acq_state, 2'h0)
        strobe(1'b0, OFF_TRIG, 32'h1);
        strobe(1'b0, OFF_CMD, 32'h1);
        strobe(1'b0, OFF_CMD, 32'h4);
        strobe(1'b0, OFF_CMD, 32'h2);
        settle(0);
        `CHK(acq_state, 2'h3)
        wait_done();
        `CHK({acq_state, last_exp}, {2'h0, e})
        $display("continuous and stop tests ended");
        strobe(1'b0, OFF_TRIG, 32'h0);
        strobe(1'b0, OFF_PERIOD, 32'h14);
        strobe(1'b0, OFF_SEL, 32'h1);
        strobe(1'b0, OFF_TRIG, 32'h1);
        strobe(1'b0, OFF_BURST, 32'h2);
        strobe(1'b0, OFF_CMD, 32'h1);
        settle(3);
        `CHK(acq_state, 2'h1)
        strobe(1'b0, OFF_CMD, 32'h4);
        wait_done();
        wait_done();
        `CHK({acq_state, frames}, {2'h1, 32'd7})
        settle(30);
        `CHK(frames, 7)
        $display("burst test ended");
        conclude();
    end
endmodule : tb_fat_acq_ctrl
